// *** verilog/ccf_ctrl.sv ***
`timescale 1ns/1ps
module ccf_ctrl (
  input wire logic I_CLK_SYS, // 40 MHz system clock
  input wire logic I_RST_N, // Async reset, active low
  input wire logic [7:0] I_SFR_ADDR, // Special-function address
  input wire logic [7:0] I_SFR_PAGE, // Current register page
  input wire logic I_SFR_WR, // Write strobe, one cycle
  input wire logic I_SFR_RD, // Read strobe, one cycle
  input wire logic [7:0] I_SFR_WDATA, // Write data
  input wire logic I_CMP_RESULT, // Raw comparator output, async
  output logic [7:0] O_SFR_RDATA, // Read data, valid cycle after strobe
  output logic O_SFR_HIT, // Read hit this register
  output logic O_CMP_ENABLE, // Comparator enable to analog core
  output logic [1:0] O_HYST_POS, // Positive hysteresis select
  output logic [1:0] O_HYST_NEG // Negative hysteresis select
);
  typedef struct packed {
    logic en;
    logic rise;
    logic fall;
    logic [1:0] hyp;
    logic [1:0] hyn;
    logic prev;
    logic [7:0] rdata;
    logic hit;
  } ccf_state_t;

  ccf_state_t s_q;
  ccf_state_t s_d;
  logic cmp_sync;
  logic sel;
  logic wr_hit;
  logic rd_hit;
  logic rise_evt;
  logic fall_evt;
  logic [7:0] reg_view;

  // Address decode shared by reads and writes
  function automatic logic ccf_decode(input logic [7:0] addr, input logic [7:0] page);
    ccf_decode = (addr == ccf_pkg::CTRL_ADDR) && (page == ccf_pkg::CTRL_PAGE);
  endfunction : ccf_decode

  // Comparator output brought into the clock domain
  ccf_sync u_sync (
    .i_clk(I_CLK_SYS),
    .i_rst_n(I_RST_N),
    .i_async(I_CMP_RESULT),
    .o_sync(cmp_sync)
  );

  // Strobe qualification and edge events
  always_comb begin
    sel = ccf_decode(I_SFR_ADDR, I_SFR_PAGE);
    wr_hit = I_SFR_WR && sel;
    rd_hit = I_SFR_RD && sel;
    rise_evt = s_q.en && cmp_sync && !s_q.prev;
    fall_evt = s_q.en && !cmp_sync && s_q.prev;
  end

  // Register image as software sees it
  always_comb begin
    reg_view = '0;
    reg_view[ccf_pkg::ENABLE_BIT] = s_q.en;
    reg_view[ccf_pkg::RESULT_BIT] = s_q.en && cmp_sync;
    reg_view[ccf_pkg::RISE_BIT] = s_q.rise;
    reg_view[ccf_pkg::FALL_BIT] = s_q.fall;
    reg_view[ccf_pkg::HYP_MSB:ccf_pkg::HYP_LSB] = s_q.hyp;
    reg_view[ccf_pkg::HYN_MSB:ccf_pkg::HYN_LSB] = s_q.hyn;
  end

  // Next-state: writes, sticky flags with set over clear, read capture
  always_comb begin
    s_d = s_q;
    s_d.prev = cmp_sync;
    if (wr_hit) begin
      s_d.en = I_SFR_WDATA[ccf_pkg::ENABLE_BIT];
      s_d.rise = I_SFR_WDATA[ccf_pkg::RISE_BIT];
      s_d.fall = I_SFR_WDATA[ccf_pkg::FALL_BIT];
      s_d.hyp = I_SFR_WDATA[ccf_pkg::HYP_MSB:ccf_pkg::HYP_LSB];
      s_d.hyn = I_SFR_WDATA[ccf_pkg::HYN_MSB:ccf_pkg::HYN_LSB];
    end
    if (rise_evt) begin
      s_d.rise = 1'b1;
    end
    if (fall_evt) begin
      s_d.fall = 1'b1;
    end
    s_d.rdata = rd_hit ? reg_view : 8'h00;
    s_d.hit = rd_hit;
  end

  // State register, all control bits zero at reset
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign O_SFR_RDATA = s_q.rdata;
  assign O_SFR_HIT = s_q.hit;
  assign O_CMP_ENABLE = s_q.en;
  assign O_HYST_POS = s_q.hyp;
  assign O_HYST_NEG = s_q.hyn;

  // Assertion clock and reset
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RST_N);

  // Bus accesses that hit this register
  sequence s_ctrl_write;
    I_SFR_WR && ccf_decode(I_SFR_ADDR, I_SFR_PAGE);
  endsequence

  sequence s_ctrl_read;
    I_SFR_RD && ccf_decode(I_SFR_ADDR, I_SFR_PAGE);
  endsequence

  a_miss_write_ignored:
  assert property ((I_SFR_WR && !ccf_decode(I_SFR_ADDR, I_SFR_PAGE)) |=>
    $stable(O_CMP_ENABLE) && $stable(O_HYST_POS) && $stable(O_HYST_NEG))
    else $error("Write to other address changed control");

  a_read_result_bit:
  assert property (s_ctrl_read |=>
    O_SFR_HIT &&
    O_SFR_RDATA[ccf_pkg::RESULT_BIT] == ($past(O_CMP_ENABLE) && $past(cmp_sync)))
    else $error("Result bit does not match comparator");

  a_rise_flag_sticky:
  assert property ((s_q.en && cmp_sync && !s_q.prev) |=> s_q.rise ##1 (s_q.rise || $past(I_SFR_WR)))
    else $error("Rise flag not set or lost");

  a_fall_flag_sticky:
  assert property ((s_q.en && !cmp_sync && s_q.prev) |=> s_q.fall)
    else $error("Fall flag not set on falling edge");

  a_pos_hyst_write:
  assert property (s_ctrl_write |=> O_HYST_POS == $past(I_SFR_WDATA[3:2]))
    else $error("Positive hysteresis not written");

  a_neg_hyst_write:
  assert property (s_ctrl_write |=> O_HYST_NEG == $past(I_SFR_WDATA[1:0]))
    else $error("Negative hysteresis not written");

  a_disabled_no_flags:
  assert property ((!O_CMP_ENABLE && !I_SFR_WR) |=> $stable(s_q.rise) && $stable(s_q.fall))
    else $error("Edge flag changed while disabled");

  // Edge events as seen by the flag logic
  sequence s_rise_seen;
    s_q.en && cmp_sync && !s_q.prev;
  endsequence

  sequence s_fall_seen;
    s_q.en && !cmp_sync && s_q.prev;
  endsequence

  // Read path: image, misses and the hit pulse
  a_read_idle_zero:
  assert property (!(I_SFR_RD && ccf_decode(I_SFR_ADDR, I_SFR_PAGE)) |=>
    !O_SFR_HIT && O_SFR_RDATA == 8'h00)
    else $error("Read data or hit set without a hitting read");

  a_read_control_image:
  assert property (s_ctrl_read |=>
    O_SFR_RDATA[ccf_pkg::ENABLE_BIT] == $past(O_CMP_ENABLE) &&
    O_SFR_RDATA[ccf_pkg::HYP_MSB:ccf_pkg::HYP_LSB] == $past(O_HYST_POS) &&
    O_SFR_RDATA[ccf_pkg::HYN_MSB:ccf_pkg::HYN_LSB] == $past(O_HYST_NEG))
    else $error("Read image differs from control outputs");

  a_read_rise_bit:
  assert property (s_ctrl_read |=> O_SFR_RDATA[ccf_pkg::RISE_BIT] == $past(s_q.rise))
    else $error("Rise flag not reported on read");

  a_read_fall_bit:
  assert property (s_ctrl_read |=> O_SFR_RDATA[ccf_pkg::FALL_BIT] == $past(s_q.fall))
    else $error("Fall flag not reported on read");

  // Enable write and the result gate
  a_enable_write:
  assert property (s_ctrl_write |=> O_CMP_ENABLE == $past(I_SFR_WDATA[ccf_pkg::ENABLE_BIT]))
    else $error("Enable bit not written");

  a_result_off_gate:
  assert property (!O_CMP_ENABLE |-> !reg_view[ccf_pkg::RESULT_BIT])
    else $error("Result bit shown while comparator disabled");

  // Flag lifetime: set over clear, hold, no spurious set
  a_rise_set_wins:
  assert property ((rise_evt && wr_hit) |=> s_q.rise)
    else $error("Clear overrode a rising edge");

  a_fall_set_wins:
  assert property ((fall_evt && wr_hit) |=> s_q.fall)
    else $error("Clear overrode a falling edge");

  a_rise_held:
  assert property ((s_rise_seen ##1 !wr_hit) |=> s_q.rise)
    else $error("Rise flag dropped without a write");

  a_fall_held:
  assert property ((s_fall_seen ##1 !wr_hit) |=> s_q.fall)
    else $error("Fall flag dropped without a write");

  a_rise_no_spurious:
  assert property ((!s_q.rise && !rise_evt && !wr_hit) |=> !s_q.rise)
    else $error("Rise flag set without an edge");

  a_fall_no_spurious:
  assert property ((!s_q.fall && !fall_evt && !wr_hit) |=> !s_q.fall)
    else $error("Fall flag set without an edge");

  // Edge history runs every cycle, enabled or not
  a_history_tracks:
  assert property (1'b1 |=> s_q.prev == $past(cmp_sync))
    else $error("Edge history lost the synchronised level");
endmodule : ccf_ctrl

// *** verilog/ccf_pkg.sv ***
package ccf_pkg;
  // Register location on the special-function bus
  localparam logic [7:0] CTRL_ADDR = 8'h9d;
  localparam logic [7:0] CTRL_PAGE = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Field positions
  localparam int ENABLE_BIT = 7;
  localparam int RESULT_BIT = 6;
  localparam int RISE_BIT = 5;
  localparam int FALL_BIT = 4;
  localparam int HYP_MSB = 3;
  localparam int HYP_LSB = 2;
  localparam int HYN_MSB = 1;
  localparam int HYN_LSB = 0;
  // Hysteresis codes
  localparam logic [1:0] HYST_OFF = 2'h0;
  localparam logic [1:0] HYST_5MV = 2'h1;
  localparam logic [1:0] HYST_10MV = 2'h2;
  localparam logic [1:0] HYST_20MV = 2'h3;
  // Synchroniser depth in cycles
  localparam int SYNC_STAGES = 2;
endpackage : ccf_pkg

// *** verilog/ccf_sync.sv ***
`timescale 1ns/1ps
module ccf_sync (
  input wire logic i_clk, // System clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic i_async, // Level from outside the clock domain
  output logic o_sync // Synchronised level
);
  typedef struct packed {
    logic stage1;
    logic stage2;
  } ccf_sync_st_t;

  ccf_sync_st_t s_q;
  ccf_sync_st_t s_d;

  // Two-flop chain, first stage read only by the second
  always_comb begin
    s_d = s_q;
    s_d.stage1 = i_async;
    s_d.stage2 = s_q.stage1;
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_sync = s_q.stage2;
endmodule : ccf_sync

// *** tb/ccf_cmp_model.sv ***
`timescale 1ns/1ps
module ccf_cmp_model (
  input wire logic i_pos_above, // Positive input above negative input
  output logic o_out // Comparator output toward the block
);
  // Output follows the sign of the input difference
  assign o_out = i_pos_above;
endmodule : ccf_cmp_model

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, pos_above = 0, cmp, hit, en;
  logic [7:0] addr = 8'h00, page = 8'h00, wdata = 8'h00, rdata;
  logic [1:0] hp, hn;
  int err_count = 0, checks = 0;
  // Rows: written value, expected control outputs, expected readback
  logic [7:0] rows [5][3] = '{'{8'hc5, 8'h85, 8'h85}, '{8'h8a, 8'h8a, 8'h8a},
    '{8'h80, 8'h80, 8'h80}, '{8'h0f, 8'h0f, 8'h0f}, '{8'h30, 8'h00, 8'h30}};
  ccf_cmp_model i_core (.i_pos_above(pos_above), .o_out(cmp));
  ccf_ctrl i_dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_SFR_ADDR(addr), .I_SFR_PAGE(page),
    .I_SFR_WR(wr), .I_SFR_RD(rd), .I_SFR_WDATA(wdata), .I_CMP_RESULT(cmp),
    .O_SFR_RDATA(rdata), .O_SFR_HIT(hit), .O_CMP_ENABLE(en), .O_HYST_POS(hp),
    .O_HYST_NEG(hn));
  // Clock, 25 ns period
  initial forever #12.5 clk = ~clk;
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #2 wr = 1;
    addr = a;
    wdata = d;
    @(posedge clk);
    #2 wr = 0;
  endtask : wr_reg
  task rd_reg(input logic [7:0] a);
    @(posedge clk);
    #2 rd = 1;
    addr = a;
    @(posedge clk);
    #2 rd = 0;
  endtask : rd_reg
  task stop_test;
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  // Watchdog
  initial begin
    #20us;
    err_count++;
    stop_test();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    #2 rst_n = 1;
    rd_reg(8'h9d);
    chk(rdata, 8'h00);
    chk({7'h0, hit}, 8'h01);
    foreach (rows[i]) begin
      wr_reg(8'h9d, rows[i][0]);
      chk({en, 3'h0, hp, hn}, rows[i][1]);
      rd_reg(8'h9d);
      chk(rdata, rows[i][2]);
    end
    wr_reg(8'h9d, 8'h80);
    pos_above = 1;
    repeat (5) @(posedge clk);
    rd_reg(8'h9d);
    chk(rdata, 8'he0);
    wr_reg(8'h9d, 8'h80);
    rd_reg(8'h9d);
    chk(rdata, 8'hc0);
    pos_above = 0;
    repeat (5) @(posedge clk);
    rd_reg(8'h9d);
    chk(rdata, 8'h90);
    pos_above = 1;
    @(posedge clk);
    wr_reg(8'h9d, 8'h80);
    rd_reg(8'h9d);
    chk(rdata, 8'he0);
    wr_reg(8'h9d, 8'h00);
    pos_above = 0;
    repeat (5) @(posedge clk);
    rd_reg(8'h9d);
    chk(rdata, 8'h00);
    pos_above = 1;
    repeat (5) @(posedge clk);
    rd_reg(8'h9d);
    chk(rdata, 8'h00);
    wr_reg(8'h9d, 8'h80);
    repeat (2) @(posedge clk);
    rd_reg(8'h9d);
    chk(rdata, 8'hc0);
    rd_reg(8'h9e);
    chk(rdata, 8'h00);
    chk({7'h0, hit}, 8'h00);
    page = 8'h01;
    wr_reg(8'h9d, 8'h85);
    page = 8'h00;
    chk({en, 3'h0, hp, hn}, 8'h80);
    wr_reg(8'h9d, 8'h8f);
    chk({en, 3'h0, hp, hn}, 8'h8f);
    rst_n = 0;
    #5 chk({en, 3'h0, hp, hn}, 8'h00);
    @(posedge clk);
    #2 rst_n = 1;
    @(posedge clk);
    #2 chk({en, 3'h0, hp, hn}, 8'h00);
    rd_reg(8'h9d);
    chk(rdata, 8'h00);
    chk({7'h0, hit}, 8'h01);
    stop_test();
  end
endmodule : tb_top
